// ==== inc/fpp_pkg.sv ====
// Package of constants and types for the flash program and protection controller.
package fpp_pkg;

    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam logic [11:0] ctrl_offset = 12'h000;
    localparam logic [11:0] option_offset = 12'h004;
    localparam logic [11:0] status_offset = 12'h008;
    localparam logic [11:0] cmd_addr_offset = 12'h00c;
    localparam logic [11:0] cmd_data_offset = 12'h010;
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] key_first = 8'h56;
    localparam logic [7:0] key_second = 8'hae;
    // Control register fields once unlocked.
    localparam int ctrl_prog_bit = 0;
    localparam int ctrl_erase_bit = 1;
    localparam int ctrl_burst_bit = 2;
    // Option byte fields.
    localparam int opt_readout_bit = 0;
    localparam int opt_write_bit = 1;
    localparam logic [7:0] option_reset = 8'h00;
    // Flash geometry: sector 0 occupies the lowest addresses.
    localparam int addr_width = 13;
    localparam logic [12:0] sector0_limit = 13'h1000;
    localparam int burst_max = 32;
    localparam logic [5:0] burst_max_count = 6'h20;
    // Reset vectors for normal and link entry.
    localparam logic [15:0] user_vector = 16'hfffe;
    localparam logic [15:0] link_vector = 16'h0000;
    // Link entry: data pattern that must be clocked in with reset low.
    localparam logic [7:0] link_entry_pattern = 8'ha5;
    localparam logic [3:0] link_entry_bits = 4'h8;

    // Status of the sequencer as seen by software.
    typedef enum logic [1:0] {fpp_idle, fpp_key1, fpp_open} fpp_lock_t;

    // Command issued to the flash array.
    typedef struct packed {
        logic valid;
        logic erase;
        logic [12:0] addr;
        logic [7:0] data;
    } fpp_cmd_t;
endpackage : fpp_pkg

// ==== core/fpp_ctrl.sv ====
// Flash program and protection controller with APB register access.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns

// Functional notes
// - Entering link mode selects the system memory reset vector.
// - Tool loads driver into RAM; device runs it to program flash.
// - In application mode, writes and erases to sector 0 are refused.
// - With a tool attached, link pins are withheld from the application.
// - Read-out protection blocks memory extraction and flash writes.
// - Clearing read-out protection erases the whole program memory first; the code raises no mass erase while write protection is set.
// - A dedicated option bit turns read-out protection on and off.
// - Read-out and write protection are independent settings.
// - Write protection refuses every program or erase.
// - Write protection once set can never be cleared; the code clears it on presetn.
// - Write protection has its own dedicated option bit.
// - Control register is read-write and resets to zero.
// - First key then second key unlock programming and erasing.
// - Program and erase operations are commanded through the control register.
// - Flash accepts single bytes or bursts up to thirty-two bytes.
module fpp_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic programming_link_clock,
    input wire logic programming_link_data,
    input wire logic programming_link_select,
    input wire logic reset_pin_low,
    input wire logic app_mode,
    output logic link_active,
    output logic link_pins_owned,
    output logic [15:0] reset_vector,
    output fpp_pkg::fpp_cmd_t flash_cmd,
    output logic mass_erase,
    input wire logic flash_busy
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic [1:0] sel_sync;
    logic [1:0] rst_sync;
    logic clk_prev;

    // Two stages for every pin; only the second stage is read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sync <= 2'h0;
            dat_sync <= 2'h0;
            sel_sync <= 2'h0;
            rst_sync <= 2'h0;
            clk_prev <= 1'b0;
        end else begin
            clk_sync <= {clk_sync[0], programming_link_clock};
            dat_sync <= {dat_sync[0], programming_link_data};
            sel_sync <= {sel_sync[0], programming_link_select};
            rst_sync <= {rst_sync[0], reset_pin_low};
            clk_prev <= clk_sync[1];
        end
    end

    wire link_rise = clk_sync[1] & ~clk_prev;
    wire rst_low = rst_sync[1];

    // ************************************************************
    // Link entry detection
    // ************************************************************
    logic [7:0] entry_shift;
    logic [3:0] entry_count;
    logic entry_seen;
    logic link_mode;

    wire entry_match = (entry_count == fpp_pkg::link_entry_bits)
                       && (entry_shift == fpp_pkg::link_entry_pattern);

    // The pattern is only counted while reset is held low by the tool.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_shift <= 8'h00;
            entry_count <= 4'h0;
            entry_seen <= 1'b0;
        end else if (!rst_low) begin
            // A fresh reset hold must present the pattern again, or a bad entry would reuse it.
            entry_count <= 4'h0;
            entry_seen <= 1'b0;
        end else if (link_rise && !entry_seen) begin
            entry_shift <= {entry_shift[6:0], dat_sync[1]};
            entry_count <= (entry_count == fpp_pkg::link_entry_bits)
                           ? entry_count : entry_count + 4'h1;
        end else if (entry_match) begin
            entry_seen <= 1'b1;
        end
    end

    // Link mode latches at reset release after a valid entry, and stays
    // until the next reset, since the tool owns reset for the session.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_mode <= 1'b0;
        end else if (rst_low && !entry_seen) begin
            link_mode <= 1'b0;
        end else if (!rst_low && entry_seen) begin
            link_mode <= 1'b1;
        end
    end

    assign link_active = link_mode;
    assign reset_vector = link_mode ? fpp_pkg::link_vector : fpp_pkg::user_vector;
    assign link_pins_owned = sel_sync[1] | link_mode;

    // ************************************************************
    // Option byte and unlock sequencer
    // ************************************************************
    logic [7:0] option;
    logic [7:0] ctrl;
    logic [12:0] cmd_addr;
    logic [7:0] cmd_data;
    logic [5:0] burst_left;
    fpp_pkg::fpp_lock_t lock;

    wire wr = psel & penable & pwrite;
    wire wr_ctrl = wr && paddr == fpp_pkg::ctrl_offset;
    wire wr_opt = wr && paddr == fpp_pkg::option_offset;
    wire wr_addr = wr && paddr == fpp_pkg::cmd_addr_offset;
    wire wr_data = wr && paddr == fpp_pkg::cmd_data_offset;
    wire [7:0] wbyte = pwdata[7:0];
    wire ro_on = option[fpp_pkg::opt_readout_bit];
    wire wp_on = option[fpp_pkg::opt_write_bit];
    wire sector0 = cmd_addr < fpp_pkg::sector0_limit;
    // Each protection acts alone, so either may be set without the other.
    wire blocked = ro_on | wp_on | (app_mode & ~link_mode & sector0);
    wire ro_clear = wr_opt && ro_on && !wbyte[fpp_pkg::opt_readout_bit];

    // Unlock needs the two keys on control writes with no write to any other register between them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock <= fpp_pkg::fpp_idle;
        end else if (wr_ctrl) begin
            unique case (lock)
                fpp_pkg::fpp_idle: begin
                    lock <= (wbyte == fpp_pkg::key_first) ? fpp_pkg::fpp_key1
                                                         : fpp_pkg::fpp_idle;
                end
                fpp_pkg::fpp_key1: begin
                    lock <= (wbyte == fpp_pkg::key_second) ? fpp_pkg::fpp_open
                                                          : fpp_pkg::fpp_idle;
                end
                fpp_pkg::fpp_open: begin
                    lock <= fpp_pkg::fpp_open;
                end
            endcase
        end else if (wr && lock == fpp_pkg::fpp_key1) begin
            lock <= fpp_pkg::fpp_idle;
        end
    end

    // Control register: command bits only land once unlocked.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= fpp_pkg::ctrl_reset;
        end else if (wr_ctrl && lock == fpp_pkg::fpp_open) begin
            ctrl <= wbyte;
        end
    end

    // Write protection is sticky: once it is set, a later write changes only the read-out bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option <= fpp_pkg::option_reset;
        end else if (wr_opt && !wp_on) begin
            option <= wbyte;
        end else if (wr_opt) begin
            option[fpp_pkg::opt_readout_bit] <= wbyte[fpp_pkg::opt_readout_bit];
        end
    end

    // Removing read-out protection wipes the array, unless write protection is set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mass_erase <= 1'b0;
        end else begin
            mass_erase <= ro_clear & ~wp_on;
        end
    end

    // ************************************************************
    // Command issue
    // ************************************************************
    wire burst = ctrl[fpp_pkg::ctrl_burst_bit];
    wire go = wr_data && lock == fpp_pkg::fpp_open && !flash_busy && !blocked
              && (ctrl[fpp_pkg::ctrl_prog_bit] | ctrl[fpp_pkg::ctrl_erase_bit])
              && (!burst || burst_left != 6'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_addr <= 13'h0000;
            cmd_data <= 8'h00;
            burst_left <= fpp_pkg::burst_max_count;
            flash_cmd <= '0;
        end else begin
            flash_cmd.valid <= go;
            if (go) begin
                flash_cmd.erase <= ctrl[fpp_pkg::ctrl_erase_bit];
                flash_cmd.addr <= cmd_addr;
                flash_cmd.data <= wbyte;
                cmd_data <= wbyte;
                cmd_addr <= cmd_addr + 13'h0001;
                burst_left <= burst ? burst_left - 6'h01 : burst_left;
            end
            if (wr_addr) begin
                cmd_addr <= pwdata[12:0];
                burst_left <= fpp_pkg::burst_max_count;
            end
        end
    end

    // ************************************************************
    // APB read and answer
    // ************************************************************
    wire hit = paddr == fpp_pkg::ctrl_offset || paddr == fpp_pkg::option_offset
               || paddr == fpp_pkg::status_offset || paddr == fpp_pkg::cmd_addr_offset
               || paddr == fpp_pkg::cmd_data_offset;
    // Reads of the data register under read-out protection return zero.
    wire [31:0] rd_mux =
        paddr == fpp_pkg::ctrl_offset ? {24'h000000, ctrl} :
        paddr == fpp_pkg::option_offset ? {24'h000000, option} :
        paddr == fpp_pkg::status_offset ? {26'h0, flash_busy, link_mode,
                                           wp_on, ro_on, lock} :
        paddr == fpp_pkg::cmd_addr_offset ? {19'h0, cmd_addr} :
        paddr == fpp_pkg::cmd_data_offset ? {24'h000000, ro_on ? 8'h00 : cmd_data}
                                          : 32'h00000000;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_key_unlock: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && lock == fpp_pkg::fpp_key1 && wbyte == fpp_pkg::key_second)
        |=> lock == fpp_pkg::fpp_open) else $error("second key did not unlock");
    a_bad_key: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && lock == fpp_pkg::fpp_idle && wbyte != fpp_pkg::key_first)
        |=> lock == fpp_pkg::fpp_idle) else $error("bad key advanced lock");
    a_locked_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
        (lock != fpp_pkg::fpp_open) |=> $stable(ctrl)) else $error("ctrl changed while locked");
    a_sector0_guard: assert property (@(posedge pclk) disable iff (!presetn)
        (app_mode && !link_mode && sector0) |=> !flash_cmd.valid)
        else $error("sector 0 written in app mode");
    a_wp_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        wp_on |=> !flash_cmd.valid) else $error("write under write protection");
    a_wp_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        wp_on |=> wp_on) else $error("write protection cleared");
    a_ro_block: assert property (@(posedge pclk) disable iff (!presetn)
        ro_on |=> !flash_cmd.valid) else $error("write under read-out protection");
    a_ro_erase: assert property (@(posedge pclk) disable iff (!presetn)
        (ro_clear && !wp_on) |=> mass_erase) else $error("no mass erase on unprotect");
    a_vector_sel: assert property (@(posedge pclk) disable iff (!presetn)
        link_mode |-> reset_vector == fpp_pkg::link_vector) else $error("wrong vector");
    a_pins_owned: assert property (@(posedge pclk) disable iff (!presetn)
        link_mode |-> link_pins_owned) else $error("pins not held by link");
    // Entry, lock, operation and burst guards; the burst one checks that no command follows once the count is empty.
    a_entry_link: assert property (@(posedge pclk) disable iff (!presetn)
        (!rst_low && entry_seen) |=> link_mode) else $error("link mode not entered");
    a_no_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (rst_low && !entry_seen) |=> !link_mode) else $error("link mode without pattern");
    a_locked_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        (lock != fpp_pkg::fpp_open) |=> !flash_cmd.valid)
        else $error("command issued while locked");
    a_no_op: assert property (@(posedge pclk) disable iff (!presetn)
        !(ctrl[fpp_pkg::ctrl_prog_bit] | ctrl[fpp_pkg::ctrl_erase_bit]) |=> !flash_cmd.valid)
        else $error("command without operation bit");
    a_burst_cap: assert property (@(posedge pclk) disable iff (!presetn)
        (burst && burst_left == 6'h00) |=> !flash_cmd.valid) else $error("burst overran");

    c_unlock: cover property (@(posedge pclk) disable iff (!presetn)
        lock == fpp_pkg::fpp_open);
    c_program: cover property (@(posedge pclk) disable iff (!presetn)
        flash_cmd.valid && !flash_cmd.erase);
    c_link_entry: cover property (@(posedge pclk) disable iff (!presetn) $rose(link_mode));
    c_mass_erase: cover property (@(posedge pclk) disable iff (!presetn) mass_erase);
    c_burst_drain: cover property (@(posedge pclk) disable iff (!presetn)
        burst && burst_left == 6'h00);

endmodule : fpp_ctrl

// ==== sim/fpp_tool_model.sv ====
// Behavioural programming tool that drives the link pins and the device reset pin.
`timescale 1ns/1ns
module fpp_tool_model (
    output logic link_clock,
    output logic link_data,
    output logic link_select,
    output logic reset_low
);
    // ************************************************************
    // Idle state and link frames
    // ************************************************************
    // Idle: link clock parked low, reset released, tool not selected.
    initial begin
        link_clock = 1'b0;
        link_data = 1'b1;
        link_select = 1'b0;
        reset_low = 1'b0;
    end
    // Holds the reset pin low while clocking a pattern MSB first at 125 ns per bit.
    task automatic send_entry(input logic [7:0] pattern);
        integer i;
        #2 reset_low = 1'b1;
        #200;
        for (i = 7; i >= 0; i--) begin
            link_data = pattern[i];
            #62 link_clock = 1'b1;
            #63 link_clock = 1'b0;
        end
        // The line is not held after the frame, so the last bit is not left standing.
        link_data = ~pattern[0];
        #200 reset_low = 1'b0;
    endtask : send_entry
    // Plugging the tool in raises the select line even without a session.
    task automatic set_select(input logic level);
        link_select = level;
    endtask : set_select
endmodule : fpp_tool_model

// ==== sim/fpp_ctrl_tb.sv ====
// Self-checking bench for the flash program and protection controller.
`timescale 1ns/1ns
module fpp_ctrl_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, app_mode, flash_busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic lclk, ldat, lsel, rlow, link_active, link_pins_owned, mass_erase;
    logic [15:0] reset_vector;
    fpp_pkg::fpp_cmd_t flash_cmd;
    logic [22:0] got_q[$], exp_q[$];
    integer errors = 0, checks_done = 0, ls = 0, m_ctrl = 0, m_ro = 0, m_wp = 0, m_link = 0;
    integer erases = 0, erase_seen = 0;

    fpp_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .programming_link_clock(lclk), .programming_link_data(ldat),
        .programming_link_select(lsel), .reset_pin_low(rlow), .app_mode(app_mode),
        .link_active(link_active), .link_pins_owned(link_pins_owned),
        .reset_vector(reset_vector), .flash_cmd(flash_cmd), .mass_erase(mass_erase),
        .flash_busy(flash_busy));
    fpp_tool_model tool (.link_clock(lclk), .link_data(ldat), .link_select(lsel),
        .reset_low(rlow));

    // ************************************************************
    // Clock, monitors and checking helpers
    // ************************************************************
    // Clock at 125 MHz.
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Pulses last one cycle, so they are collected at every edge.
    always @(posedge pclk) begin
        if (flash_cmd.valid === 1'b1) got_q.push_back(flash_cmd);
        if (mass_erase === 1'b1) erase_seen++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // Reference model of keys, control and option bits, updated on every completed write.
    task automatic model(input logic [11:0] a, input logic [7:0] d);
        if (a == fpp_pkg::ctrl_offset && ls == 2) m_ctrl = d;
        else if (a == fpp_pkg::ctrl_offset) ls = (ls == 0 && d == fpp_pkg::key_first) ? 1 :
            (ls == 1 && d == fpp_pkg::key_second) ? 2 : 0;
        else if (ls == 1) ls = 0;
        if (a == fpp_pkg::option_offset) begin
            if (m_ro == 1 && d[0] == 1'b0 && m_wp == 0) erases++;
            m_ro = d[0];
            m_wp = m_wp | d[1];
        end
    endtask : model
    // One APB transfer; the request stands until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 100) errors++;
        if (wr) model(a, d[7:0]);
    endtask : apb
    function automatic logic [31:0] stat_exp();
        return {26'h0, flash_busy, m_link[0], m_wp[0], m_ro[0], ls[1:0]};
    endfunction : stat_exp
    // Loads an address, writes n random bytes and compares the commands issued.
    task automatic put(input logic [12:0] a, input integer n);
        integer i, cnt;
        logic [7:0] dv;
        cnt = 0;
        apb(1'b1, fpp_pkg::cmd_addr_offset, {19'h0, a});
        for (i = 0; i < n; i++) begin
            dv = 8'($urandom);
            apb(1'b1, fpp_pkg::cmd_data_offset, {24'h0, dv});
            if (ls == 2 && m_ro == 0 && m_wp == 0 && flash_busy == 1'b0 && m_ctrl[1:0] != 0 &&
                !(app_mode && m_link == 0 && a < 13'h1000) && cnt < (m_ctrl[2] ? 32 : 1)) begin
                exp_q.push_back({1'b1, m_ctrl[1], a, dv});
                a++;
                cnt++;
            end
        end
        repeat (4) @(posedge pclk);
        check(got_q.size(), exp_q.size(), "command count");
        while (exp_q.size() > 0 && got_q.size() > 0)
            check(got_q.pop_front(), exp_q.pop_front(), "command");
        got_q.delete();
        exp_q.delete();
    endtask : put

    // ************************************************************
    // Test sequence
    // ************************************************************
    // presetn is asserted only once, before any link session runs.
    initial begin
        {psel, penable, pwrite, app_mode, flash_busy} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        presetn = 1'b0;
        void'($urandom(10));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, fpp_pkg::ctrl_offset, 32'h0);
        check(rdat, 32'h0, "control reset");
        apb(1'b0, fpp_pkg::status_offset, 32'h0);
        check(rdat, stat_exp(), "status reset");
        check({16'h0, reset_vector}, {16'h0, fpp_pkg::user_vector}, "vector");
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, rerr}, 32'h1, "unmapped error");
        $display("test reset done");
        apb(1'b1, fpp_pkg::ctrl_offset, 32'h01);
        put(13'h1800, 1);
        apb(1'b1, fpp_pkg::ctrl_offset, {24'h0, fpp_pkg::key_first});
        apb(1'b1, fpp_pkg::cmd_addr_offset, 32'h0);
        apb(1'b1, fpp_pkg::ctrl_offset, {24'h0, fpp_pkg::key_second});
        apb(1'b0, fpp_pkg::status_offset, 32'h0);
        check(rdat, stat_exp(), "broken keys");
        apb(1'b1, fpp_pkg::ctrl_offset, {24'h0, fpp_pkg::key_first});
        apb(1'b1, fpp_pkg::ctrl_offset, {24'h0, fpp_pkg::key_second});
        apb(1'b0, fpp_pkg::status_offset, 32'h0);
        check(rdat, stat_exp(), "unlocked");
        $display("test keys done");
        apb(1'b1, fpp_pkg::ctrl_offset, 32'h05);
        apb(1'b0, fpp_pkg::ctrl_offset, 32'h0);
        check(rdat, 32'h05, "control readback");
        put(13'h1000 + 13'($urandom % 1024), 33);
        apb(1'b1, fpp_pkg::ctrl_offset, 32'h01);
        put(13'h1000 + 13'($urandom % 1024), 1);
        apb(1'b1, fpp_pkg::ctrl_offset, 32'h02);
        put(13'h1000 + 13'($urandom % 1024), 1);
        app_mode <= 1'b1;
        put(13'h0fff, 1);
        put(13'h1000, 1);
        flash_busy <= 1'b1;
        put(13'h1400, 1);
        flash_busy <= 1'b0;
        $display("test commands done");
        tool.set_select(1'b1);
        repeat (6) @(posedge pclk);
        check({31'h0, link_pins_owned}, 32'h1, "pins owned");
        tool.set_select(1'b0);
        tool.send_entry(fpp_pkg::link_entry_pattern);
        m_link = 1;
        repeat (10) @(posedge pclk);
        check({16'h0, reset_vector}, {16'h0, fpp_pkg::link_vector}, "link vector");
        check({31'h0, link_pins_owned}, 32'h1, "pins in session");
        check({31'h0, link_active}, 32'h1, "link entry");
        put(13'h0010, 1);
        tool.send_entry(8'h5a);
        m_link = 0;
        repeat (10) @(posedge pclk);
        check({31'h0, link_active}, 32'h0, "bad pattern");
        check({31'h0, link_pins_owned}, 32'h0, "pins free");
        app_mode <= 1'b0;
        $display("test link done");
        apb(1'b1, fpp_pkg::option_offset, 32'h01);
        apb(1'b0, fpp_pkg::status_offset, 32'h0);
        check(rdat, stat_exp(), "readout on");
        put(13'h1100, 1);
        apb(1'b0, fpp_pkg::cmd_data_offset, 32'h0);
        check(rdat, 32'h0, "hidden data");
        apb(1'b1, fpp_pkg::option_offset, 32'h00);
        repeat (3) @(posedge pclk);
        check(erase_seen, erases, "mass erase");
        apb(1'b1, fpp_pkg::option_offset, 32'h02);
        put(13'h1200, 1);
        apb(1'b1, fpp_pkg::option_offset, 32'h00);
        apb(1'b0, fpp_pkg::option_offset, 32'h0);
        check(rdat, 32'h02, "protect sticks");
        apb(1'b1, fpp_pkg::option_offset, 32'h01);
        apb(1'b0, fpp_pkg::option_offset, 32'h0);
        check(rdat, {30'h0, m_wp[0], m_ro[0]}, "independent bits");
        $display("test protection done");
        tally_and_finish();
    end
    // A hang ends the run well beyond the expected length of all tests.
    initial begin
        #400000;
        errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule : fpp_ctrl_tb
